// file: design/phsm_pkg.sv
// Shared constants, types and register map of the strap loader and MAC port block
package phsm_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] REG_STRAPS = 8'h00;
    localparam logic [7:0] REG_BASIC_CTRL = 8'h04;
    localparam logic [7:0] REG_ADVERT = 8'h08;
    localparam logic [7:0] REG_RX_DATA = 8'h0C;
    localparam logic [7:0] REG_TX_DATA = 8'h10;
    localparam logic [7:0] REG_LINK_STATUS = 8'h14;

    // Basic control field positions
    localparam int BC_LOOPBACK_BIT = 14;
    localparam int BC_SPEED_BIT = 13;
    localparam int BC_AUTONEG_BIT = 12;
    localparam int BC_POWERDOWN_BIT = 11;
    localparam int BC_ISOLATE_BIT = 10;
    localparam int BC_DUPLEX_BIT = 8;

    // Advertisement field positions and selector
    localparam int ADV_100FD_BIT = 8;
    localparam int ADV_100HD_BIT = 7;
    localparam int ADV_10FD_BIT = 6;
    localparam int ADV_10HD_BIT = 5;
    localparam logic [4:0] ADV_SELECTOR = 5'h01;

    // Reset values
    localparam logic [4:0] MGMT_ADDR_DEFAULT = 5'h01;
    localparam logic [15:0] BC_RESET = 16'h3100;
    localparam logic [15:0] ADV_RESET = 16'h01E1;

    // Link steps per byte, and serial 10 Mb/s segment repeats, given as last index
    localparam logic [3:0] MII_LAST_UNIT = 4'h1;
    localparam logic [3:0] RMII_LAST_UNIT = 4'h3;
    localparam logic [3:0] SMII_LAST_UNIT = 4'h9;
    localparam logic [3:0] SMII_LAST_REP_10M = 4'h9;

    // Serial segment layout: bit 0 carrier or error, bit 1 valid or enable, bits 9:2 data
    localparam int SEG_EN_BIT = 1;
    localparam int SEG_DATA_LSB = 2;

    typedef enum logic [1:0] {
        PORT_MII = 2'b00,
        PORT_RMII = 2'b01,
        PORT_SMII = 2'b11
    } phsm_port_mode_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_SEND = 2'b01
    } phsm_rx_state_t;

    // Pins that carry a strap during reset and a MAC-side function afterwards
    typedef struct packed {
        logic [3:0] rxd;
        logic rxdv;
        logic rxc;
        logic rxer;
        logic col;
        logic crs;
        logic intrN;
        logic indicatorOne;
        logic indicatorTwo;
        logic indicatorThree;
    } phsm_shared_t;

    // Values frozen at the end of chip reset
    typedef struct packed {
        logic [4:0] mgmtAddressStrap;
        logic codingLoopbackStrap;
        logic serialPortModeStrap;
        logic isolateStrap;
        logic reducedModeStrap;
        logic reducedBackToBackStrap;
        logic speedSelectStrap;
        logic duplexStrap;
        logic autonegEnableStrap;
        logic fiberModeEnable;
    } phsm_straps_t;

    localparam phsm_straps_t STRAPS_RESET = '{
        mgmtAddressStrap: MGMT_ADDR_DEFAULT,
        codingLoopbackStrap: 1'b0,
        serialPortModeStrap: 1'b0,
        isolateStrap: 1'b0,
        reducedModeStrap: 1'b0,
        reducedBackToBackStrap: 1'b0,
        speedSelectStrap: 1'b1,
        duplexStrap: 1'b1,
        autonegEnableStrap: 1'b1,
        fiberModeEnable: 1'b0
    };

endpackage

// file: design/phsm_port_core.sv
// Strap capture, MAC-side MII/RMII/SMII port and Wishbone register file
module phsm_port_core
    import phsm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic linkClk,
    input wire logic chipRstN,
    input wire logic powerDownN,
    input wire logic fiberModeEnable,
    input wire logic [3:0] txd,
    input wire logic txEn,
    input wire phsm_shared_t sharedIn,
    output phsm_shared_t sharedOut,
    output phsm_shared_t sharedOeN
);

    localparam int SYNC_W = 22;
    // Synchroniser rest value: reset and power-down pins idle high, so no false chip reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {3'b011, {(SYNC_W - 3){1'b0}}};

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Last step index of a byte in each port mode
    function automatic logic [3:0] lastUnit(input phsm_port_mode_t m);
        case (m)
            PORT_MII: lastUnit = MII_LAST_UNIT;
            PORT_RMII: lastUnit = RMII_LAST_UNIT;
            PORT_SMII: lastUnit = SMII_LAST_UNIT;
            default: lastUnit = MII_LAST_UNIT;
        endcase
    endfunction

    // Last repeat index: serial mode at 10 Mb/s repeats every segment
    function automatic logic [3:0] lastRep(input phsm_port_mode_t m, input logic fast);
        lastRep = (m == PORT_SMII && !fast) ? SMII_LAST_REP_10M : 4'h0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [SYNC_W-1:0] syncA_q;
    logic [SYNC_W-1:0] syncB_q;
    logic linkPrev_q;
    logic linkS;
    logic chipRstNS;
    logic powerDownNS;
    logic fiberS;
    logic txEnS;
    logic [3:0] txdS;
    phsm_shared_t sharedS;
    logic linkRise;

    // Two flops on every pin input
    always_ff @(posedge clk) begin
        if (srst) begin
            syncA_q <= SYNC_IDLE;
            syncB_q <= SYNC_IDLE;
            linkPrev_q <= 1'b0;
        end else if (ce) begin
            syncA_q <= {linkClk, chipRstN, powerDownN, fiberModeEnable, txEn, txd, sharedIn};
            syncB_q <= syncA_q;
            linkPrev_q <= linkS;
        end
    end

    assign {linkS, chipRstNS, powerDownNS, fiberS, txEnS, txdS, sharedS} = syncB_q;
    assign linkRise = linkS && !linkPrev_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture and configuration state

    logic chipRstActive;
    phsm_straps_t straps_q;
    phsm_straps_t strapSample;
    logic [15:0] basicCtrl_q;
    logic [15:0] advert_q;
    phsm_port_mode_t portMode;
    logic speed100;
    logic isolate;
    logic loopback;
    logic powerDown;
    logic farEndFaultOff;
    logic wbWrite;

    assign chipRstActive = !chipRstNS;

    // Strap values as seen on the shared pins, and the fiber mode pin
    always_comb begin
        strapSample.mgmtAddressStrap = {sharedS.rxd[0], sharedS.rxd[1], sharedS.rxd[2],
                                        sharedS.rxd[3], sharedS.intrN};
        strapSample.codingLoopbackStrap = sharedS.rxdv;
        strapSample.serialPortModeStrap = sharedS.rxc;
        strapSample.isolateStrap = sharedS.rxer;
        strapSample.reducedModeStrap = sharedS.col;
        strapSample.reducedBackToBackStrap = sharedS.crs;
        strapSample.speedSelectStrap = sharedS.indicatorOne;
        strapSample.duplexStrap = sharedS.indicatorTwo;
        strapSample.autonegEnableStrap = sharedS.indicatorThree;
        strapSample.fiberModeEnable = fiberS;
    end

    // Follow the pins while reset is held, then hold the last sample
    always_ff @(posedge clk) begin
        if (srst) begin
            straps_q <= STRAPS_RESET;
        end else if (ce && chipRstActive) begin
            straps_q <= strapSample;
        end
    end

    // Advertisement seeded from speed and duplex straps
    always_ff @(posedge clk) begin
        if (srst) begin
            advert_q <= ADV_RESET;
        end else if (ce && chipRstActive) begin
            advert_q <= {11'h000, ADV_SELECTOR};
            advert_q[ADV_100FD_BIT] <= strapSample.speedSelectStrap
                && strapSample.duplexStrap;
            advert_q[ADV_100HD_BIT] <= strapSample.speedSelectStrap;
            advert_q[ADV_10FD_BIT] <= strapSample.duplexStrap;
            advert_q[ADV_10HD_BIT] <= 1'b1;
        end
    end

    // Basic control: strap-seeded during reset, software-writable afterwards
    always_ff @(posedge clk) begin
        if (srst) begin
            basicCtrl_q <= BC_RESET;
        end else if (ce) begin
            if (chipRstActive) begin
                basicCtrl_q <= 16'h0000;
                basicCtrl_q[BC_SPEED_BIT] <= strapSample.speedSelectStrap;
                basicCtrl_q[BC_DUPLEX_BIT] <= strapSample.duplexStrap;
                basicCtrl_q[BC_AUTONEG_BIT] <= strapSample.autonegEnableStrap;
                basicCtrl_q[BC_ISOLATE_BIT] <= strapSample.isolateStrap;
                basicCtrl_q[BC_LOOPBACK_BIT] <= strapSample.codingLoopbackStrap;
            end else if (wbWrite && wb_adr_i == REG_BASIC_CTRL) begin
                if (wb_sel_i[0]) begin
                    basicCtrl_q[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    basicCtrl_q[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    // Port mode: serial strap wins over reduced strap
    always_comb begin
        if (straps_q.serialPortModeStrap) begin
            portMode = PORT_SMII;
        end else if (straps_q.reducedModeStrap) begin
            portMode = PORT_RMII;
        end else begin
            portMode = PORT_MII;
        end
    end

    assign speed100 = basicCtrl_q[BC_SPEED_BIT];
    assign isolate = basicCtrl_q[BC_ISOLATE_BIT];
    assign loopback = basicCtrl_q[BC_LOOPBACK_BIT];
    assign powerDown = !powerDownNS || basicCtrl_q[BC_POWERDOWN_BIT];
    assign farEndFaultOff = straps_q.fiberModeEnable && !straps_q.speedSelectStrap;

    ////////////////////////////////////////////////////////////////////////////////
    // Link step and transmit capture

    logic step;
    logic [3:0] txUnit_q;
    logic [3:0] txRep_q;
    logic [9:0] txAsm_q;
    logic [7:0] txByte_q;
    logic [7:0] txCount_q;
    logic txDone;
    logic [7:0] txDoneByte;
    logic [3:0] lastU;
    logic [3:0] lastR;

    assign step = ce && linkRise && !chipRstActive && !powerDown;
    assign lastU = lastUnit(portMode);
    assign lastR = lastRep(portMode, speed100);

    // Byte completion for each port mode
    always_comb begin
        txDone = 1'b0;
        txDoneByte = 8'h00;
        case (portMode)
            PORT_MII: begin
                txDone = txEnS && txUnit_q == lastU;
                txDoneByte = {txdS, txAsm_q[3:0]};
            end
            PORT_RMII: begin
                txDone = txEnS && txUnit_q == lastU;
                txDoneByte = {txdS[1:0], txAsm_q[5:0]};
            end
            PORT_SMII: begin
                txDone = txRep_q == 4'h0 && txUnit_q == lastU && txAsm_q[SEG_EN_BIT];
                txDoneByte = {txdS[0], txAsm_q[8:SEG_DATA_LSB]};
            end
            default: begin
                txDone = 1'b0;
                txDoneByte = 8'h00;
            end
        endcase
    end

    // Transmit counters: nibbles and dibits only while enabled, segments free-running
    always_ff @(posedge clk) begin
        if (srst) begin
            txUnit_q <= 4'h0;
            txRep_q <= 4'h0;
            txAsm_q <= 10'h000;
        end else if (step) begin
            if (portMode != PORT_SMII && !txEnS) begin
                txUnit_q <= 4'h0;
            end else begin
                if (txRep_q == 4'h0) begin
                    case (portMode)
                        PORT_MII: txAsm_q[{txUnit_q[0], 2'b00} +: 4] <= txdS;
                        PORT_RMII: txAsm_q[{txUnit_q[1:0], 1'b0} +: 2] <= txdS[1:0];
                        PORT_SMII: txAsm_q[txUnit_q] <= txdS[0];
                        default: txAsm_q <= txAsm_q;
                    endcase
                end
                if (txUnit_q == lastU) begin
                    txUnit_q <= 4'h0;
                    txRep_q <= (txRep_q == lastR) ? 4'h0 : txRep_q + 4'h1;
                end else begin
                    txUnit_q <= txUnit_q + 4'h1;
                end
            end
        end
    end

    // Last received transmit byte and a running count
    always_ff @(posedge clk) begin
        if (srst) begin
            txByte_q <= 8'h00;
            txCount_q <= 8'h00;
        end else if (step && txDone) begin
            txByte_q <= txDoneByte;
            txCount_q <= txCount_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive engine

    phsm_rx_state_t rxState_q;
    logic [3:0] rxUnit_q;
    logic [3:0] rxRep_q;
    logic [7:0] rxCur_q;
    logic [7:0] rxHold_q;
    logic rxPending_q;
    logic rxSlotEnd;
    logic rxTake;
    logic rxBusy;
    logic swRxWrite;
    logic [9:0] rxSeg;

    assign rxBusy = rxState_q == RX_SEND;
    assign rxSlotEnd = rxUnit_q == lastU && rxRep_q == lastR;
    assign rxTake = step && (!rxBusy || rxSlotEnd);
    assign swRxWrite = wbWrite && wb_adr_i == REG_RX_DATA && wb_sel_i[0];
    assign rxSeg = {rxCur_q, rxBusy, rxBusy};

    // Byte waiting to be sent: loopback or software fills, a new fill wins over a take
    always_ff @(posedge clk) begin
        if (srst) begin
            rxPending_q <= 1'b0;
            rxHold_q <= 8'h00;
        end else if (ce) begin
            if (step && txDone && loopback) begin
                rxPending_q <= 1'b1;
                rxHold_q <= txDoneByte;
            end else if (swRxWrite) begin
                rxPending_q <= 1'b1;
                rxHold_q <= wb_dat_i[7:0];
            end else if (rxTake) begin
                rxPending_q <= 1'b0;
            end
        end
    end

    // Walk the byte out in nibbles, dibits or repeated segments
    always_ff @(posedge clk) begin
        if (srst) begin
            rxState_q <= RX_IDLE;
            rxUnit_q <= 4'h0;
            rxRep_q <= 4'h0;
            rxCur_q <= 8'h00;
        end else if (step) begin
            if (!rxBusy || rxSlotEnd) begin
                rxUnit_q <= 4'h0;
                rxRep_q <= 4'h0;
                rxState_q <= rxPending_q ? RX_SEND : RX_IDLE;
                rxCur_q <= rxPending_q ? rxHold_q : 8'h00;
            end else if (rxUnit_q == lastU) begin
                rxUnit_q <= 4'h0;
                rxRep_q <= rxRep_q + 4'h1;
            end else begin
                rxUnit_q <= rxUnit_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers

    // Shared pins released during reset; data pins released when isolated
    always_ff @(posedge clk) begin
        if (srst) begin
            sharedOeN <= '1;
        end else if (ce) begin
            if (chipRstActive) begin
                sharedOeN <= '1;
            end else begin
                sharedOeN <= '0;
                sharedOeN.rxd <= {4{isolate}};
                sharedOeN.rxdv <= isolate;
                sharedOeN.rxer <= isolate;
                sharedOeN.crs <= isolate;
                sharedOeN.col <= isolate;
            end
        end
    end

    // Receive data pins change on link steps, and clear during chip reset or power-down
    always_ff @(posedge clk) begin
        if (srst) begin
            sharedOut.rxd <= 4'h0;
            sharedOut.rxdv <= 1'b0;
        end else if (ce && (chipRstActive || powerDown)) begin
            sharedOut.rxd <= 4'h0;
            sharedOut.rxdv <= 1'b0;
        end else if (step) begin
            case (portMode)
                PORT_MII: begin
                    sharedOut.rxd <= rxBusy ? rxCur_q[{rxUnit_q[0], 2'b00} +: 4] : 4'h0;
                    sharedOut.rxdv <= rxBusy;
                end
                PORT_RMII: begin
                    sharedOut.rxd <= {2'b00, rxBusy ? rxCur_q[{rxUnit_q[1:0], 1'b0} +: 2]
                                                    : 2'b00};
                    sharedOut.rxdv <= rxBusy;
                end
                PORT_SMII: begin
                    sharedOut.rxd <= {3'b000, rxSeg[rxUnit_q]};
                    sharedOut.rxdv <= 1'b0;
                end
                default: begin
                    sharedOut.rxd <= 4'h0;
                    sharedOut.rxdv <= 1'b0;
                end
            endcase
        end
    end

    // Clock echo, status and indicator pins
    always_ff @(posedge clk) begin
        if (srst) begin
            sharedOut.rxc <= 1'b0;
            sharedOut.rxer <= 1'b0;
            sharedOut.col <= 1'b0;
            sharedOut.crs <= 1'b0;
            sharedOut.intrN <= 1'b1;
            sharedOut.indicatorOne <= 1'b0;
            sharedOut.indicatorTwo <= 1'b0;
            sharedOut.indicatorThree <= 1'b0;
        end else if (ce) begin
            sharedOut.rxc <= linkS && !powerDown;
            sharedOut.rxer <= 1'b0;
            sharedOut.col <= !basicCtrl_q[BC_DUPLEX_BIT] && rxBusy && txEnS;
            sharedOut.crs <= (rxBusy || txEnS) && !powerDown;
            sharedOut.intrN <= 1'b1;
            sharedOut.indicatorOne <= speed100;
            sharedOut.indicatorTwo <= basicCtrl_q[BC_DUPLEX_BIT];
            sharedOut.indicatorThree <= rxBusy || txEnS;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    logic [31:0] readWord;

    assign wbWrite = ce && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    // Read decode; unmapped offsets read as zero
    always_comb begin
        case (wb_adr_i)
            REG_STRAPS: readWord = {18'h00000, straps_q};
            REG_BASIC_CTRL: readWord = {16'h0000, basicCtrl_q};
            REG_ADVERT: readWord = {16'h0000, advert_q};
            REG_RX_DATA: readWord = {22'h000000, rxPending_q, rxBusy, rxHold_q};
            REG_TX_DATA: readWord = {16'h0000, txCount_q, txByte_q};
            REG_LINK_STATUS: readWord = {26'h0000000, farEndFaultOff, powerDown,
                                         straps_q.reducedBackToBackStrap, chipRstActive,
                                         portMode};
            default: readWord = 32'h00000000;
        endcase
    end

    // One wait state: ack follows a new request, drops the cycle after
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= readWord;
            end
        end
    end

endmodule // phsm_port_core

// file: sim/phsm_mac_model.sv
// MAC transmit side for MII and RMII
module phsm_mac_model
    import phsm_pkg::*;
(
    input wire logic linkClk,
    input wire phsm_port_mode_t mode,
    input wire logic go,
    input wire logic [7:0] byteIn,
    output logic [3:0] txd = 4'h0,
    output logic txEn = 1'b0,
    output logic busy = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int k = 0;
    logic [7:0] sh;
    // Lines change mid period; idle data keeps toggling
    always @(negedge linkClk) begin
        if (k == 0 && go) begin
            k = (mode == PORT_MII) ? 2 : 4;
            sh = byteIn;
        end
        busy = (k != 0);
        if (k != 0) begin
            txEn = 1'b1;
            txd = (mode == PORT_MII) ? sh[3:0] : {~sh[1:0], sh[1:0]};
            sh = (mode == PORT_MII) ? sh >> 4 : sh >> 2;
            k--;
        end else begin
            txEn = 1'b0;
            txd = ~txd;
        end
    end
endmodule // phsm_mac_model

// file: sim/phsm_port_core_assertions.sv
// Pin and bus checks for the strap loader and MAC port
module phsm_port_core_assertions
    import phsm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic chipRstN,
    input wire logic powerDownN,
    input wire phsm_shared_t sharedOut,
    input wire phsm_shared_t sharedOeN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic req;
    // A request not yet answered
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    property p_ackNext; req |=> wb_ack_o; endproperty
    a_ackNext: assert property (p_ackNext) else $error("no ack after request");
    property p_ackPulse; wb_ack_o && ce |=> !wb_ack_o; endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
    property p_ackOnlyReq; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    a_ackOnlyReq: assert property (p_ackOnlyReq) else $error("ack without request");
    property p_unmapped; req && !wb_we_i && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_advSel; req && !wb_we_i && wb_adr_i == REG_ADVERT |=> wb_dat_o[4:0] == 5'h01; endproperty
    a_advSel: assert property (p_advSel) else $error("advert selector wrong");
    property p_strapIn; !chipRstN [*4] |=> &sharedOeN; endproperty
    a_strapIn: assert property (p_strapIn) else $error("pin driven in chip reset");
    property p_drivenAfter; (chipRstN && powerDownN && ce && !srst) [*6] |-> !sharedOeN.indicatorOne; endproperty
    a_drivenAfter: assert property (p_drivenAfter) else $error("pin not driven");
    property p_powerDown; (!powerDownN && ce) [*5] |-> sharedOut.rxdv == 1'b0 && sharedOut.rxd == 4'h0; endproperty
    a_powerDown: assert property (p_powerDown) else $error("receive active in power down");
    property p_rxHold; $changed(sharedOut.rxd) && chipRstN && powerDownN
        |=> ($stable(sharedOut.rxd) || !chipRstN || !powerDownN) [*8]; endproperty
    a_rxHold: assert property (p_rxHold) else $error("receive data not held");
endmodule // phsm_port_core_assertions

bind phsm_port_core phsm_port_core_assertions u_chk (.clk, .srst, .ce, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .chipRstN, .powerDownN, .sharedOut, .sharedOeN);

// file: sim/test_phsm_port_core.sv
// Self-checking bench for the strap loader and MAC port
module test_phsm_port_core
    import phsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, linkClk = 1'b0, chipRstN = 1'b1, powerDownN = 1'b1;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, fiber = 1'b0, wbAck, txEn, busy, go = 1'b0;
    logic [7:0] wbAdr = 8'h00, txByte = 8'h00, rxByte, b, c0;
    logic [31:0] wbDat = 32'h0, wbQ, rd;
    logic [3:0] txd;
    phsm_port_mode_t mode = PORT_MII;
    phsm_shared_t pins = '0, sharedIn, sharedOut, sharedOeN, p;
    int n_fail = 0, checked = 0, cyc = 0, nibs = 0, seed = 32'h4efb4a9d;
    // Pin level: external strap resistor unless the device drives
    assign sharedIn = (sharedOeN & pins) | (~sharedOeN & sharedOut);
    initial forever #5 clk = ~clk;
    initial begin
        #3;
        forever #80 linkClk = ~linkClk;
    end
    phsm_port_core DUT (.clk, .srst, .ce(1'b1), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(4'hF), .wb_dat_o(wbQ),
        .wb_ack_o(wbAck), .linkClk, .chipRstN, .powerDownN, .fiberModeEnable(fiber), .txd,
        .txEn, .sharedIn, .sharedOut, .sharedOeN);
    phsm_mac_model mac (.linkClk, .mode, .go, .byteIn(txByte), .txd, .txEn, .busy);
    // Collects receive nibbles, or dibits in RMII, mid link period
    always @(negedge linkClk) begin
        if (sharedOut.rxdv === 1'b1) begin
            rxByte = (mode == PORT_RMII) ? {sharedOut.rxd[1:0], rxByte[7:2]}
                                         : {sharedOut.rxd, rxByte[7:4]};
            nibs++;
        end
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Classic single Wishbone cycle; read data lands in rd
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDat <= d;
        do begin
            @(posedge clk);
        end while (wbAck !== 1'b1);
        rd = wbQ;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chipReset(input phsm_shared_t s, input logic f);
        pins <= s;
        fiber <= f;
        chipRstN <= 1'b0;
        repeat (5000) @(posedge clk);
        chipRstN <= 1'b1;
        repeat (10) @(posedge clk);
    endtask
    task automatic send();
        txByte <= 8'($random(seed));
        go <= 1'b1;
        for (int t = 0; t < 200 && busy !== 1'b1; t++) @(posedge clk);
        go <= 1'b0;
        for (int t = 0; t < 200 && busy !== 1'b0; t++) @(posedge clk);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        wb(1'b0, REG_STRAPS, 32'h0);
        check("straps", rd, {18'h0, STRAPS_RESET});
        wb(1'b0, REG_BASIC_CTRL, 32'h0);
        check("control", rd, {16'h0, BC_RESET});
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
        $display("test defaults done");
        for (int i = 0; i < 6; i++) begin
            p = (i < 2) ? {13{i[0]}} : 13'($random(seed));
            chipReset(p, i[0] ^ p.rxd[0]);
            pins <= 13'($random(seed));
            repeat (20) @(posedge clk);
            wb(1'b0, REG_STRAPS, 32'h0);
            check("straps", rd, {18'h0, p.rxd[0], p.rxd[1], p.rxd[2], p.rxd[3], p.intrN, p.rxdv,
                p.rxc, p.rxer, p.col, p.crs, p.indicatorOne, p.indicatorTwo, p.indicatorThree,
                fiber});
            wb(1'b0, REG_BASIC_CTRL, 32'h0);
            check("control", rd, {17'h0, p.rxdv, p.indicatorOne, p.indicatorThree, 1'b0, p.rxer,
                1'b0, p.indicatorTwo, 8'h00});
            wb(1'b0, REG_ADVERT, 32'h0);
            check("advert", rd, {23'h0, p.indicatorOne & p.indicatorTwo, p.indicatorOne,
                p.indicatorTwo, 1'b1, ADV_SELECTOR});
            wb(1'b0, REG_LINK_STATUS, 32'h0);
            check("status", rd, {26'h0, fiber & ~p.indicatorOne, 1'b0, p.crs, 1'b0,
                p.rxc ? 2'b11 : {1'b0, p.col}});
            check("pins", {sharedOut.intrN, sharedOut.rxer, sharedOut.col, sharedOut.crs,
                sharedOut.indicatorOne, sharedOut.indicatorTwo, sharedOut.indicatorThree},
                {4'b1000, p.indicatorOne, p.indicatorTwo, 1'b0});
            $display("test straps %0d done", i);
        end
        for (int m = 0; m < 2; m++) begin
            p = 13'($random(seed));
            {p.rxdv, p.rxc, p.rxer, p.col} = {3'b000, m[0]};
            chipReset(p, 1'b0);
            mode <= m ? PORT_RMII : PORT_MII;
            for (int i = 0; i < 3; i++) begin
                nibs = 0;
                b = i ? 8'($random(seed)) : 8'hF0;
                wb(1'b1, REG_RX_DATA, {24'h0, b});
                for (int t = 0; t < 300 && nibs < 2 + 2 * m; t++) @(posedge clk);
                repeat (40) @(posedge clk);
                check("rx units", nibs, 2 + 2 * m);
                check("rx byte", rxByte, b);
            end
            if (m == 0) begin
                powerDownN <= 1'b0;
                repeat (10) @(posedge clk);
                nibs = 0;
                wb(1'b1, REG_RX_DATA, 32'h3C);
                repeat (200) @(posedge clk);
                wb(1'b0, REG_LINK_STATUS, 32'h0);
                check("power down", {rd[4], nibs[3:0]}, 5'h10);
                powerDownN <= 1'b1;
                repeat (400) @(posedge clk);
            end
            wb(1'b0, REG_TX_DATA, 32'h0);
            c0 = rd[15:8];
            repeat (3) send();
            repeat (40) @(posedge clk);
            wb(1'b0, REG_TX_DATA, 32'h0);
            check("tx", rd, {16'h0, 8'(c0 + 8'h03), txByte});
            $display("test port mode %0d done", m);
        end
        end_of_test();
    end
endmodule // test_phsm_port_core
